/* File: rtl/dbgtc_pkg.sv */
// package for the debug trigger and debug control/status csr block
package dbgtc_pkg;
    // ***********************************
    // csr addresses
    // ***********************************
    localparam logic [11:0] DBGTC_ADDR_TCMP    = 12'h7A2;
    localparam logic [11:0] DBGTC_ADDR_DCS     = 12'h7B0;

    // ***********************************
    // trigger control field positions
    // ***********************************
    localparam int          DBGTC_TC_LOAD      = 0;
    localparam int          DBGTC_TC_STORE     = 1;
    localparam int          DBGTC_TC_EXEC      = 2;
    localparam int          DBGTC_TC_MEN       = 6;

    // ***********************************
    // debug control/status field positions and values
    // ***********************************
    localparam int          DBGTC_DCS_VER_LSB  = 28;
    localparam int          DBGTC_DCS_BRKM     = 15;
    localparam int          DBGTC_DCS_STEPIE   = 11;
    localparam int          DBGTC_DCS_STOPCNT  = 10;
    localparam int          DBGTC_DCS_STOPTIM  = 9;
    localparam int          DBGTC_DCS_CAUSE_LSB = 6;
    localparam logic [3:0]  DBGTC_DCS_VER      = 4'h4;
    localparam logic [31:0] DBGTC_TCMP_RST     = 32'h0000_0000;
    localparam logic [2:0]  DBGTC_TC_RST       = 3'h0;

    // ***********************************
    // entry cause codes
    // ***********************************
    localparam logic [2:0]  DBGTC_CAUSE_NONE   = 3'h0;
    localparam logic [2:0]  DBGTC_CAUSE_BRK    = 3'h1;
    localparam logic [2:0]  DBGTC_CAUSE_TRIG   = 3'h2;
    localparam logic [2:0]  DBGTC_CAUSE_HALT   = 3'h3;
    localparam logic [2:0]  DBGTC_CAUSE_STEP   = 3'h4;
    localparam logic [2:0]  DBGTC_CAUSE_RHALT  = 3'h5;

    // csr access from the pipeline
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } dbgtc_csr_req_s;

    // pipeline events that can enter debug mode
    typedef struct packed {
        logic        trig;
        logic        brk;
        logic        rhalt;
        logic        halt;
        logic        step;
    } dbgtc_entry_s;

    // memory-side activity compared by the trigger
    typedef struct packed {
        logic        ex_vld;
        logic [31:0] ex_addr;
        logic        ld_vld;
        logic [31:0] ld_addr;
        logic        st_vld;
        logic [31:0] st_addr;
        logic [31:0] st_data;
    } dbgtc_mem_s;

    // block state
    typedef struct packed {
        logic [2:0]  ttype;
        logic        men;
        logic [31:0] tcmp;
        logic        brkm;
        logic        stepie;
        logic        stopcnt;
        logic [2:0]  cause;
        logic [31:0] rdata;
        logic        illegal;
        logic        hit;
        logic        brk_dbg;
        logic        brk_exc;
        logic        int_ok;
        logic        cnt_en;
    } dbgtc_state_s;
endpackage

/* File: rtl/dbgtc_csr.sv */
// debug trigger match and debug control/status csr logic for an m-mode-only core
`timescale 1ns/10ps
module dbgtc_csr
    import dbgtc_pkg::*;
(
    input  wire logic                     clk,          // core clock, 40 MHz
    input  wire logic                     rst_b,        // async reset, active low
    input  wire dbgtc_pkg::dbgtc_csr_req_s csr_req,     // csr read/write request
    input  wire logic [2:0]               tc_type_wdata, // trigger type bits to load
    input  wire logic                     tc_men_wdata, // trigger m-mode enable to load
    input  wire logic                     tc_wr,        // trigger control write strobe
    input  wire logic                     dbg_mode,     // hart in debug mode
    input  wire logic                     stepping,     // single step in progress
    input  wire logic                     brk_exec,     // breakpoint instr in m-mode
    input  wire dbgtc_pkg::dbgtc_entry_s  entry,        // debug entry reasons this cycle
    input  wire dbgtc_pkg::dbgtc_mem_s    mem,          // addresses/data to compare
    output logic [31:0]                   csr_rdata,    // read data, one cycle later
    output logic                          csr_illegal,  // illegal access pulse
    output logic                          trig_hit,     // trigger match pulse
    output logic                          brk_to_dbg,   // breakpoint enters debug
    output logic                          brk_to_exc,   // breakpoint takes exception
    output logic                          int_allow,    // interrupts permitted
    output logic                          cnt_en,       // counters may increment
    output logic [2:0]                    tc_type,      // trigger type bits
    output logic                          tc_men        // trigger m-mode enable
);
    import dbgtc_pkg::*;

    // ***********************************
    // reset release
    // ***********************************
    logic rst_s1_r;
    logic rst_b_r;

    // two-stage release keeps deassertion synchronous
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_b_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_r  <= rst_s1_r;
        end
    end

    // ***********************************
    // helpers
    // ***********************************
    // priority pick of entry cause
    function automatic logic [2:0] pick_cause(input dbgtc_entry_s e);
        logic [2:0] c;
        c = DBGTC_CAUSE_NONE;
        if (e.trig) c = DBGTC_CAUSE_TRIG;
        else if (e.brk) c = DBGTC_CAUSE_BRK;
        else if (e.rhalt) c = DBGTC_CAUSE_RHALT;    // full code kept
        else if (e.halt) c = DBGTC_CAUSE_HALT;
        else if (e.step) c = DBGTC_CAUSE_STEP;
        return c;
    endfunction

    // full view of the control/status word
    function automatic logic [31:0] dcs_word(input dbgtc_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;                           // fixed zeros
        w[DBGTC_DCS_VER_LSB +: 4]   = DBGTC_DCS_VER;
        w[DBGTC_DCS_BRKM]           = s.brkm;
        w[DBGTC_DCS_STEPIE]         = s.stepie;
        w[DBGTC_DCS_STOPCNT]        = s.stopcnt;
        w[DBGTC_DCS_CAUSE_LSB +: 3] = s.cause;
        return w;
    endfunction

    // ***********************************
    // state
    // ***********************************
    dbgtc_state_s st_r;
    dbgtc_state_s st_nxt;
    logic         acc;
    logic         m_exec;
    logic         m_ld;
    logic         m_st;

    // compares: instruction match masks bit zero
    assign m_exec = mem.ex_vld && st_r.ttype[DBGTC_TC_EXEC]
                    && (mem.ex_addr[31:1] == st_r.tcmp[31:1]);
    assign m_st   = mem.st_vld && st_r.ttype[DBGTC_TC_STORE]
                    && (mem.st_addr == st_r.tcmp || mem.st_data == st_r.tcmp);
    assign m_ld   = mem.ld_vld && st_r.ttype[DBGTC_TC_LOAD]
                    && (mem.ld_addr == st_r.tcmp);
    assign acc    = csr_req.rd | csr_req.wr;

    // next-state: csr access, trigger, cause capture
    always_comb begin
        st_nxt         = st_r;
        st_nxt.illegal = 1'b0;
        st_nxt.rdata   = 32'h0000_0000;
        if (tc_wr) begin
            st_nxt.ttype = tc_type_wdata;
            st_nxt.men   = tc_men_wdata;
        end
        if (acc && csr_req.addr == DBGTC_ADDR_TCMP) begin
            st_nxt.rdata = st_r.tcmp;
            if (csr_req.wr) st_nxt.tcmp = csr_req.wdata;
        end else if (acc && csr_req.addr == DBGTC_ADDR_DCS) begin
            if (!dbg_mode) begin
                st_nxt.illegal = 1'b1;
            end else begin
                st_nxt.rdata = dcs_word(st_r);
                if (csr_req.wr) begin
                    // only writable bits are taken
                    st_nxt.brkm    = csr_req.wdata[DBGTC_DCS_BRKM];
                    st_nxt.stepie  = csr_req.wdata[DBGTC_DCS_STEPIE];
                    st_nxt.stopcnt = csr_req.wdata[DBGTC_DCS_STOPCNT];
                end
            end
        end
        // hardware cause update beats any write
        if (|entry) st_nxt.cause = pick_cause(entry);
        st_nxt.hit     = st_r.men && (m_exec || m_st || m_ld) && !dbg_mode;
        st_nxt.brk_dbg = brk_exec && !dbg_mode && st_r.brkm;
        st_nxt.brk_exc = brk_exec && !dbg_mode && !st_r.brkm;
        st_nxt.int_ok  = !dbg_mode && (!stepping || st_r.stepie);
        st_nxt.cnt_en  = !(st_r.stopcnt && (dbg_mode
                          || (brk_exec && st_r.brkm)));
    end

    // register the whole state
    always_ff @(posedge clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            st_r        <= '0;
            st_r.ttype  <= DBGTC_TC_RST;
            st_r.tcmp   <= DBGTC_TCMP_RST;
            st_r.int_ok <= 1'b1;
            st_r.cnt_en <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign csr_rdata   = st_r.rdata;
    assign csr_illegal = st_r.illegal;
    assign trig_hit    = st_r.hit;
    assign brk_to_dbg  = st_r.brk_dbg;
    assign brk_to_exc  = st_r.brk_exc;
    assign int_allow   = st_r.int_ok;
    assign cnt_en      = st_r.cnt_en;
    assign tc_type     = st_r.ttype;
    assign tc_men      = st_r.men;

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b_r);

    a_dcs_illegal_acc: assert property (
        (csr_req.rd && csr_req.addr == DBGTC_ADDR_DCS && !dbg_mode) |=> csr_illegal)
        else $error("control/status access outside debug not flagged");
    a_dcs_ver_four: assert property (
        (csr_req.rd && csr_req.addr == DBGTC_ADDR_DCS && dbg_mode)
        |=> csr_rdata[31:28] == DBGTC_DCS_VER)
        else $error("version field not four");
    a_dcs_zero_bits: assert property (
        (csr_req.rd && csr_req.addr == DBGTC_ADDR_DCS && dbg_mode)
        |=> (csr_rdata[27:16] == 12'h000 && csr_rdata[14:12] == 3'h0 && !csr_rdata[9]))
        else $error("fixed-zero bits read nonzero");
    a_tcmp_write_read: assert property (
        (csr_req.wr && csr_req.addr == DBGTC_ADDR_TCMP) ##1 !csr_req.wr
        ##1 (csr_req.rd && !csr_req.wr && csr_req.addr == DBGTC_ADDR_TCMP)
        |=> csr_rdata == $past(csr_req.wdata, 3))
        else $error("compare value not read back");
    a_exec_bit0_mask: assert property (
        (mem.ex_vld && st_r.ttype == 3'h4 && st_r.men && !dbg_mode && !tc_wr
         && mem.ex_addr[31:1] == st_r.tcmp[31:1]) |=> trig_hit)
        else $error("instruction match missed");
    a_no_men_hit: assert property (
        !st_r.men |=> !trig_hit)
        else $error("trigger fired without m-mode enable");
    a_cause_prio: assert property (
        (entry.trig && entry.step) |=> st_r.cause == DBGTC_CAUSE_TRIG)
        else $error("trigger cause not preferred");
    a_brk_route: assert property (
        (brk_exec && !dbg_mode) |=> (brk_to_dbg != brk_to_exc)
        && (brk_to_dbg == $past(st_r.brkm)))
        else $error("breakpoint routed wrongly");
    a_step_int_gate: assert property (
        (stepping && !st_r.stepie) |=> !int_allow)
        else $error("interrupt allowed while stepping");
    a_cnt_freeze: assert property (
        (dbg_mode && st_r.stopcnt) |=> !cnt_en)
        else $error("counters not frozen");

    // ***********************************
    // trigger match checks
    // ***********************************
    // each type bit fires on its own access kind; data side keeps bit zero
    a_load_match: assert property (
        (mem.ld_vld && st_r.ttype[DBGTC_TC_LOAD] && st_r.men && !dbg_mode
         && mem.ld_addr == st_r.tcmp) |=> trig_hit)
        else $error("load address match missed");
    a_store_match: assert property (
        (mem.st_vld && st_r.ttype[DBGTC_TC_STORE] && st_r.men && !dbg_mode
         && (mem.st_addr == st_r.tcmp || mem.st_data == st_r.tcmp)) |=> trig_hit)
        else $error("store address or data match missed");
    a_exec_addr_miss: assert property (
        (st_r.ttype == 3'h4 && !(mem.ex_vld && mem.ex_addr[31:1] == st_r.tcmp[31:1]))
        |=> !trig_hit)
        else $error("execute trigger fired without address match");
    a_load_bit0_exact: assert property (
        (st_r.ttype == 3'h1 && mem.ld_addr[31:1] == st_r.tcmp[31:1]
         && mem.ld_addr[0] != st_r.tcmp[0]) |=> !trig_hit)
        else $error("bit zero ignored on a load match");
    a_no_hit_debug: assert property (
        dbg_mode |=> !trig_hit)
        else $error("trigger fired in debug mode");
    a_tc_load: assert property (
        tc_wr |=> (tc_type == $past(tc_type_wdata) && tc_men == $past(tc_men_wdata)))
        else $error("trigger control bits not loaded");

    // ***********************************
    // control/status checks
    // ***********************************
    // a refused write must not leak into any writable bit
    a_dcs_wr_illegal: assert property (
        (csr_req.wr && csr_req.addr == DBGTC_ADDR_DCS && !dbg_mode)
        |=> (csr_illegal && $stable(st_r.brkm) && $stable(st_r.stepie)
             && $stable(st_r.stopcnt)))
        else $error("control/status write outside debug not refused");
    a_dcs_ro_write: assert property (
        (csr_req.wr && csr_req.addr == DBGTC_ADDR_DCS && dbg_mode && !(|entry))
        |=> $stable(st_r.cause))
        else $error("cause field changed by a write");
    a_tcmp_stable: assert property (
        !(csr_req.wr && csr_req.addr == DBGTC_ADDR_TCMP) |=> $stable(st_r.tcmp))
        else $error("compare value changed without a write");

    // ***********************************
    // entry cause checks
    // ***********************************
    // one check per step of the priority ladder below the trigger, plus a hold check
    a_brk_over_rest: assert property (
        (entry.brk && !entry.trig) |=> st_r.cause == DBGTC_CAUSE_BRK)
        else $error("breakpoint cause not preferred");
    a_rhalt_cause: assert property (
        (entry.rhalt && !entry.trig && !entry.brk)
        |=> (st_r.cause == DBGTC_CAUSE_RHALT || st_r.cause == DBGTC_CAUSE_HALT))
        else $error("reset halt cause wrong");
    a_halt_over_step: assert property (
        (entry.halt && !entry.trig && !entry.brk && !entry.rhalt)
        |=> st_r.cause == DBGTC_CAUSE_HALT)
        else $error("halt request cause not preferred");
    a_step_cause: assert property (
        (entry.step && !entry.trig && !entry.brk && !entry.rhalt && !entry.halt)
        |=> st_r.cause == DBGTC_CAUSE_STEP)
        else $error("single step cause wrong");
    a_cause_hold: assert property (
        !(|entry) |=> $stable(st_r.cause))
        else $error("cause changed with no entry reason");

    // ***********************************
    // interrupt and counter gating checks
    // ***********************************
    // levels follow the mode one cycle late, as the pipeline sees them
    a_int_debug: assert property (
        dbg_mode |=> !int_allow)
        else $error("interrupt allowed in debug mode");
    a_int_run: assert property (
        (!dbg_mode && (!stepping || st_r.stepie)) |=> int_allow)
        else $error("interrupt blocked outside stepping");
    a_cnt_run: assert property (
        (!st_r.stopcnt) |=> cnt_en)
        else $error("counters frozen without freeze bit");
    a_brk_cnt_freeze: assert property (
        (brk_exec && st_r.brkm && st_r.stopcnt) |=> !cnt_en)
        else $error("counters run on breakpoint entry");

    // ***********************************
    // covers
    // ***********************************
    // main scenarios the bench is meant to reach
    c_trig_fire: cover property (trig_hit);
    c_brk_dbg: cover property (brk_to_dbg);
    c_dcs_illegal: cover property (csr_illegal);
    c_cause_step: cover property (entry.step && !entry.trig ##1 st_r.cause == 3'h4);
    c_rhalt_cause: cover property (entry.rhalt && !entry.trig && !entry.brk
        ##1 st_r.cause == DBGTC_CAUSE_RHALT);
endmodule

/* File: dv/dbgtc_host_model.sv */
// behavioural debugger model that halts and resumes the hart
`timescale 1ns/10ps
module dbgtc_host_model (
    input  wire logic clk,        // core clock
    input  wire logic halt_req,   // bench asks for a halt
    input  wire logic resume_req, // bench asks for a resume
    output logic      dbg_mode    // hart held in debug mode
);
    // debug mode follows one edge after a request, as a pipeline drain would
    initial dbg_mode = 1'b0;
    always @(posedge clk) begin
        if (halt_req) begin
            dbg_mode <= 1'b1;
        end else if (resume_req) begin
            dbg_mode <= 1'b0;
        end
    end
endmodule

/* File: dv/debug_trigger_and_control_csrs_bench.sv */
// self-checking bench for the debug trigger and control/status csr block
`timescale 1ns/10ps
module debug_trigger_and_control_csrs_bench;
    import dbgtc_pkg::*;
    logic           clk = 1'b0;
    logic           rst_b = 1'b0;
    dbgtc_csr_req_s req = '0;
    logic [2:0]     tcw = 3'h0;
    logic           menw = 1'b0;
    logic           tc_wr = 1'b0;
    logic           stepping = 1'b0;
    logic           brk_exec = 1'b0;
    dbgtc_entry_s   entry = '0;
    dbgtc_mem_s     mem = '0;
    logic           halt_req = 1'b0;
    logic           resume_req = 1'b0;
    logic           dbg_mode, illegal, hit, b_dbg, b_exc, int_allow, cnt_en, tc_men;
    logic [2:0]     tc_type;
    logic [31:0]    rdata, e, d;
    logic           illegal_q;
    logic [31:0]    rdata_q;
    logic [31:0]    seed = 32'hA04C27BE;
    int             miscompares = 0;
    int             comparisons = 0;

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    dbgtc_csr DUT (.clk(clk), .rst_b(rst_b), .csr_req(req), .tc_type_wdata(tcw),
        .tc_men_wdata(menw), .tc_wr(tc_wr), .dbg_mode(dbg_mode), .stepping(stepping),
        .brk_exec(brk_exec), .entry(entry), .mem(mem), .csr_rdata(rdata_q),
        .csr_illegal(illegal_q), .trig_hit(hit), .brk_to_dbg(b_dbg), .brk_to_exc(b_exc),
        .int_allow(int_allow), .cnt_en(cnt_en), .tc_type(tc_type), .tc_men(tc_men));
    dbgtc_host_model HOST (.clk(clk), .halt_req(halt_req), .resume_req(resume_req),
        .dbg_mode(dbg_mode));

    // ***********************************
    // helpers
    // ***********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [2:0] cause_of(input dbgtc_entry_s x);
        if (x.trig) return DBGTC_CAUSE_TRIG;
        if (x.brk) return DBGTC_CAUSE_BRK;
        if (x.rhalt) return DBGTC_CAUSE_RHALT;
        if (x.halt) return DBGTC_CAUSE_HALT;
        return DBGTC_CAUSE_STEP;
    endfunction
    // bit zero only counts for data-side matches
    function automatic logic hit_of(input logic [2:0] t, input logic [31:0] c, input dbgtc_mem_s m);
        return (t[2] && m.ex_vld && m.ex_addr[31:1] == c[31:1])
            || (t[0] && m.ld_vld && m.ld_addr == c)
            || (t[1] && m.st_vld && (m.st_addr == c || m.st_data == c));
    endfunction
    // inputs always move 1 ns after the edge so no race with the design
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // answer is latched while it stands; an idle edge keeps calls from merging
    task automatic csr(input logic wr, input logic [11:0] a, input logic [31:0] w);
        req = '{rd: !wr, wr: wr, addr: a, wdata: w};
        cyc(1);
        rdata = rdata_q;
        illegal = illegal_q;
        req = '0;
        cyc(1);
    endtask
    task automatic go(input logic h);
        halt_req = h;
        resume_req = !h;
        cyc(1);
        halt_req = 1'b0;
        resume_req = 1'b0;
        cyc(1);
    endtask
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ***********************************
    // scenarios
    // ***********************************
    initial begin
        cyc(3);
        rst_b = 1'b1;
        cyc(2);
        chk(tc_type, 0);
        chk(tc_men, 0);
        csr(0, DBGTC_ADDR_DCS, 0);
        chk(illegal, 1);
        chk(rdata, 0);
        go(1);
        csr(0, DBGTC_ADDR_TCMP, 0);
        chk(rdata, 0);
        csr(0, DBGTC_ADDR_DCS, 0);
        chk(rdata, 32'h4000_0000);
        csr(0, 12'h123, 0);
        chk(rdata, 0);
        // random register traffic; control/status written only while halted
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            csr(1, DBGTC_ADDR_TCMP, seed);
            csr(0, DBGTC_ADDR_TCMP, 0);
            chk(rdata, seed);
            seed = lfsr(seed);
            csr(1, DBGTC_ADDR_DCS, seed);
            csr(0, DBGTC_ADDR_DCS, 0);
            chk(rdata, (seed & 32'h0000_8C00) | 32'h4000_0000);
        end
        // counter freeze and stepping interrupt gate
        csr(1, DBGTC_ADDR_DCS, 32'h0000_0C00);
        cyc(1);
        chk(cnt_en, 0);
        go(0);
        stepping = 1'b1;
        cyc(2);
        chk(cnt_en, 1);
        chk(int_allow, 1);
        stepping = 1'b0;
        go(1);
        csr(1, DBGTC_ADDR_DCS, 32'h0);
        go(0);
        stepping = 1'b1;
        cyc(2);
        chk(int_allow, 0);
        stepping = 1'b0;
        // breakpoint routing with the enable off, then on
        for (int i = 0; i < 2; i++) begin
            brk_exec = 1'b1;
            cyc(1);
            brk_exec = 1'b0;
            chk({b_dbg, b_exc}, i ? 2'b10 : 2'b01);
            go(1);
            csr(1, DBGTC_ADDR_DCS, 32'h0000_8000);
            go(0);
        end
        // random trigger traffic, near-miss addresses mixed in
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            e = seed;
            csr(1, DBGTC_ADDR_TCMP, e);
            chk(illegal, 0);
            seed = lfsr(seed);
            tcw = seed[2:0];
            menw = seed[3];
            tc_wr = 1'b1;
            cyc(1);
            tc_wr = 1'b0;
            chk({tc_men, tc_type}, {menw, tcw});
            mem = '{ex_vld: seed[4], ex_addr: seed[5] ? e ^ 32'h1 : e ^ 32'h2,
                    ld_vld: seed[6], ld_addr: seed[7] ? e : e ^ 32'h1,
                    st_vld: seed[8], st_addr: seed[9] ? e : e ^ 32'h4,
                    st_data: seed[10] ? e : e ^ 32'h8};
            d = {31'h0, menw & hit_of(tcw, e, mem)};
            cyc(1);
            mem = '0;
            chk(hit, d);
        end
        // every combination of entry reasons
        go(1);
        for (int k = 1; k < 32; k++) begin
            entry = dbgtc_entry_s'(k[4:0]);
            cyc(1);
            entry = '0;
            csr(0, DBGTC_ADDR_DCS, 0);
            chk(rdata[8:6], cause_of(dbgtc_entry_s'(k[4:0])));
        end
        // write outside debug must leave the register untouched
        go(0);
        csr(1, DBGTC_ADDR_DCS, 32'hFFFF_FFFF);
        chk(illegal, 1);
        go(1);
        csr(0, DBGTC_ADDR_DCS, 0);
        chk(rdata, 32'h4000_8080);
        results();
    end

    // run needs about 550 cycles; cut a hang well beyond that
    initial begin
        #100000;
        miscompares++;
        results();
    end
endmodule
